// ==== common/spc_clk_if.sv ====
// Interface carrying the baud clock selection and generated tick between modules.
`timescale 1ns/10ps
interface spc_clk_if;
   logic [1:0] sel; // Selected source code.
   logic run; // Generator runs while high.
   logic tick; // One-cycle pulse per divisor period of the reference.
   modport ctl (output sel, output run, input tick);
   modport gen (input sel, input run, output tick);
endinterface : spc_clk_if

// ==== common/spc_defs.svh ====
// Register offsets, field positions, reset values and timing counts of the serial port config set.
`ifndef SPC_DEFS_SVH
`define SPC_DEFS_SVH
`define SPC_IDX_ACTIVATE 8'h30
`define SPC_IDX_BASE_HI 8'h60
`define SPC_IDX_BASE_LO 8'h61
`define SPC_IDX_IRQ_SEL 8'h70
`define SPC_IDX_OPTIONS 8'hf0
`define SPC_IDX_EVT_STATUS 8'hf8
`define SPC_IDX_EVT_MASK 8'hf9
`define SPC_IDX_CLK_STATUS 8'hfa
`define SPC_RST_ACTIVATE 8'h00
`define SPC_RST_BASE_HI 8'h02
`define SPC_RST_BASE_LO 8'he8
`define SPC_RST_IRQ_SEL 8'h03
`define SPC_RST_OPTIONS 8'h00
`define SPC_MASK_ACTIVATE 8'h01
`define SPC_MASK_BASE_LO 8'hf8
`define SPC_MASK_BASE_HI 8'h0f
`define SPC_MASK_IRQ_SEL 8'h0f
`define SPC_MASK_OPTIONS 8'he3
`define SPC_BIT_ENABLE 0
`define SPC_BIT_NO_RX_DELAY 7
`define SPC_BIT_IRQ_PULSE 6
`define SPC_BIT_NEW_FIFO_ERR 5
`define SPC_BASE_MIN 12'h100
`define SPC_BASE_MAX 12'hff8
`define SPC_RX_DELAY_NS 5
`define SPC_CLK_PERIOD_NS 50
`define SPC_RX_DELAY_CYC (((`SPC_RX_DELAY_NS + `SPC_CLK_PERIOD_NS - 1) / `SPC_CLK_PERIOD_NS))
`define SPC_EVT_WIDTH 4
`endif

// ==== common/spc_pkg.sv ====
// Types shared by the serial port config set modules.
package spc_pkg;
   // Baud reference source selection codes.
   typedef enum logic [1:0] {
      SPC_CLK_DIV13,
      SPC_CLK_DIV12,
      SPC_CLK_DIV1,
      SPC_CLK_DIV1625
   } spc_clk_sel_t;
   // Interrupt signalling style of the pulse shaper.
   typedef enum logic {
      SPC_IRQ_LEVEL,
      SPC_IRQ_PULSE
   } spc_irq_mode_t;
endpackage : spc_pkg

// ==== hw/spc_baud_gen.sv ====
// Fractional baud reference tick generator off the 24 MHz reference.
`timescale 1ns/10ps
`include "spc_defs.svh"
module spc_baud_gen
   import spc_pkg::*;
(
   input wire logic ref_clk, // 24 MHz reference clock.
   input wire logic ref_rstn, // Asynchronous reset, active low.
   spc_clk_if.gen clk_if // Selection in, tick out.
);
   // Accumulator state: ticks when accumulating 8 per cycle reaches the divisor in eighths.
   typedef struct packed {
      logic [7:0] acc; // Phase accumulator in eighths of a cycle.
      logic tick; // Registered tick.
   } spc_bg_state_t;
   spc_bg_state_t st_r;
   spc_bg_state_t st_nxt;

   // Divisor in eighths of a reference cycle; 1.625 is 13 eighths.
   function automatic logic [7:0] div_eighths(input logic [1:0] sel);
      case (sel)
         SPC_CLK_DIV13: div_eighths = 8'h68;
         SPC_CLK_DIV12: div_eighths = 8'h60;
         SPC_CLK_DIV1: div_eighths = 8'h08;
         SPC_CLK_DIV1625: div_eighths = 8'h0d;
         default: div_eighths = 8'h68;
      endcase
   endfunction : div_eighths

   // Next state: add eight each cycle, wrap by the divisor and tick.
   always_comb begin
      logic [7:0] sum;
      sum = st_r.acc + 8'h08;
      st_nxt = st_r;
      st_nxt.tick = 1'b0;
      if (!clk_if.run) begin
         st_nxt.acc = 8'h00;
      end else if (sum >= div_eighths(clk_if.sel)) begin
         st_nxt.acc = sum - div_eighths(clk_if.sel);
         st_nxt.tick = 1'b1;
      end else begin
         st_nxt.acc = sum;
      end
   end

   // State register.
   always_ff @(posedge ref_clk or negedge ref_rstn) begin
      if (!ref_rstn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign clk_if.tick = st_r.tick;

   // Undivided source ticks every cycle once running.
   a_div1_every: assert property (@(posedge ref_clk) disable iff (!ref_rstn)
      (clk_if.run && clk_if.sel == 2'h2) [*3] |-> clk_if.tick)
      else $error("undivided source missed a tick");
endmodule : spc_baud_gen

// ==== hw/spc_config_regs.sv ====
// APB register bank configuring one logical serial port.
`timescale 1ns/10ps
`include "spc_defs.svh"
module spc_config_regs
   import spc_pkg::*;
#(
   parameter int EVT_W = `SPC_EVT_WIDTH // Width of event status and mask.
) (
   input wire logic pclk, // APB clock, 20 MHz.
   input wire logic presetn, // Asynchronous reset, active low.
   input wire logic pclken, // Clock enable; all bus-clocked state holds while low, the baud generator keeps running.
   input wire logic psel, // APB select.
   input wire logic penable, // APB enable.
   input wire logic pwrite, // APB direction.
   input wire logic [11:0] paddr, // APB byte address.
   input wire logic [31:0] pwdata, // APB write data.
   output logic [31:0] prdata, // APB read data.
   output logic pready, // APB ready.
   output logic pslverr, // APB error for unmapped address.
   input wire logic ref_clk_24m, // 24 MHz reference in the same clock tree.
   input wire logic uart_irq_req, // Port interrupt request from the datapath.
   input wire logic fifo_err_legacy, // Legacy receive FIFO error flag.
   input wire logic fifo_err_revised, // Revised receive FIFO error flag.
   input wire logic receive_sample_clock, // Raw receive sample clock from the pin.
   output logic port_enable, // Port activated.
   output logic [11:0] io_base, // Aligned I/O base address.
   output logic io_base_valid, // Base lies within the legal window.
   output logic [3:0] irq_line, // Selected interrupt request line.
   output logic port_irq, // Interrupt toward the selected line.
   output logic fifo_err_flag, // Chosen flag for status bit 7.
   output logic rx_clk_out, // Receive sample clock, delayed or not.
   output logic baud_tick, // Baud reference tick.
   output logic irq // Block interrupt: unmasked event pending.
);
   // All state of the bank in one struct.
   typedef struct packed {
      logic [7:0] activate_r; // Activation register.
      logic [7:0] base_hi_r; // Base address high byte.
      logic [7:0] base_lo_r; // Base address low byte.
      logic [7:0] irq_sel_r; // Interrupt selection register.
      logic [7:0] options_r; // Option register.
      logic [EVT_W-1:0] evt_r; // Sticky event status.
      logic [EVT_W-1:0] mask_r; // Event mask.
      logic [31:0] rdata_r; // Registered read data.
      logic err_r; // Registered slave error.
      logic rdy_r; // Access answered this cycle.
      logic rx_s1_r; // Receive clock synchroniser stage one.
      logic rx_s2_r; // Receive clock synchroniser stage two.
      logic rx_dly_r; // Delayed receive clock copy.
      logic req_s1_r; // Request synchroniser stage one.
      logic req_s2_r; // Request synchroniser stage two.
      logic req_d_r; // Previous request for edge detect.
      logic pirq_r; // Registered port interrupt.
      logic fe_s1_r; // FIFO error synchroniser stage one.
      logic fe_s2_r; // FIFO error synchroniser stage two.
      logic fn_s1_r; // Revised flag synchroniser stage one.
      logic fn_s2_r; // Revised flag synchroniser stage two.
      logic ferr_r; // Registered chosen FIFO flag.
   } spc_state_t;

   spc_state_t st_r;
   spc_state_t st_nxt;
   spc_clk_if clk_bus ();

   // Index decode; returns an out-of-range marker for misaligned addresses or addresses with bits 11:10 set.
   function automatic logic [8:0] word_index(input logic [11:0] addr);
      if (addr[1:0] != 2'h0 || addr[11:10] != 2'h0) begin
         word_index = 9'h100;
      end else begin
         word_index = {1'b0, addr[9:2]};
      end
   endfunction : word_index

   // Known index check, used by both the read and the write path.
   function automatic logic is_mapped(input logic [8:0] idx);
      case (idx)
         {1'b0, `SPC_IDX_ACTIVATE}, {1'b0, `SPC_IDX_BASE_HI}, {1'b0, `SPC_IDX_BASE_LO},
         {1'b0, `SPC_IDX_IRQ_SEL}, {1'b0, `SPC_IDX_OPTIONS}, {1'b0, `SPC_IDX_EVT_STATUS},
         {1'b0, `SPC_IDX_EVT_MASK}, {1'b0, `SPC_IDX_CLK_STATUS}: is_mapped = 1'b1;
         default: is_mapped = 1'b0;
      endcase
   endfunction : is_mapped

   logic [8:0] idx;
   logic access;
   logic wr_en;
   logic req_rise;
   logic [EVT_W-1:0] evt_set;
   logic [15:0] base_word;

   assign idx = word_index(paddr);
   assign access = psel && penable && pclken && !st_r.rdy_r;
   // Writes land at the edge that sees pready high, as the bus master expects.
   assign wr_en = psel && penable && pclken && st_r.rdy_r && pwrite && is_mapped(idx);
   assign req_rise = st_r.req_s2_r && !st_r.req_d_r;
   assign base_word = {st_r.base_hi_r, st_r.base_lo_r};
   // Events: request edge, FIFO error edge, baud tick seen, base out of range.
   // The FIFO edge is taken from registered state only, so no loop forms through the next state.
   assign evt_set = EVT_W'({!io_base_valid && port_enable, baud_tick,
      (st_r.options_r[`SPC_BIT_NEW_FIFO_ERR] ? st_r.fn_s2_r : st_r.fe_s2_r) && !st_r.ferr_r,
      req_rise});

   // Next-state logic for registers, bus and pin conditioning.
   always_comb begin
      st_nxt = st_r;
      st_nxt.rdy_r = 1'b0;
      st_nxt.rx_s1_r = receive_sample_clock;
      st_nxt.rx_s2_r = st_r.rx_s1_r;
      st_nxt.rx_dly_r = st_r.rx_s2_r;
      st_nxt.req_s1_r = uart_irq_req;
      st_nxt.req_s2_r = st_r.req_s1_r;
      st_nxt.req_d_r = st_r.req_s2_r;
      st_nxt.fe_s1_r = fifo_err_legacy;
      st_nxt.fe_s2_r = st_r.fe_s1_r;
      st_nxt.fn_s1_r = fifo_err_revised;
      st_nxt.fn_s2_r = st_r.fn_s1_r;
      // Revised flag replaces the legacy one when bit 5 is set.
      st_nxt.ferr_r = st_r.options_r[`SPC_BIT_NEW_FIFO_ERR] ? st_r.fn_s2_r : st_r.fe_s2_r;
      // Level mode follows the request; pulse mode gives one cycle per rising edge.
      if (!st_r.activate_r[`SPC_BIT_ENABLE]) begin
         st_nxt.pirq_r = 1'b0;
      end else if (st_r.options_r[`SPC_BIT_IRQ_PULSE] == SPC_IRQ_PULSE) begin
         st_nxt.pirq_r = req_rise;
      end else begin
         st_nxt.pirq_r = st_r.req_s2_r;
      end
      // Write path: reserved bits are masked off so they stay zero.
      if (wr_en) begin
         case (idx[7:0])
            `SPC_IDX_ACTIVATE: st_nxt.activate_r = pwdata[7:0] & `SPC_MASK_ACTIVATE;
            `SPC_IDX_BASE_HI: st_nxt.base_hi_r = pwdata[7:0] & `SPC_MASK_BASE_HI;
            `SPC_IDX_BASE_LO: st_nxt.base_lo_r = pwdata[7:0] & `SPC_MASK_BASE_LO;
            `SPC_IDX_IRQ_SEL: st_nxt.irq_sel_r = pwdata[7:0] & `SPC_MASK_IRQ_SEL;
            `SPC_IDX_OPTIONS: st_nxt.options_r = pwdata[7:0] & `SPC_MASK_OPTIONS;
            `SPC_IDX_EVT_MASK: st_nxt.mask_r = pwdata[EVT_W-1:0];
            default: ;
         endcase
      end
      // Sticky events: write-one clears, but a new event wins.
      if (wr_en && idx[7:0] == `SPC_IDX_EVT_STATUS) begin
         st_nxt.evt_r = (st_r.evt_r & ~pwdata[EVT_W-1:0]) | evt_set;
      end else begin
         st_nxt.evt_r = st_r.evt_r | evt_set;
      end
      // Read path, answered one cycle into the access phase.
      if (access) begin
         st_nxt.rdy_r = 1'b1;
         st_nxt.err_r = !is_mapped(idx);
         st_nxt.rdata_r = 32'h0;
         if (!pwrite) begin
            case (idx[7:0])
               `SPC_IDX_ACTIVATE: st_nxt.rdata_r = {24'h0, st_r.activate_r};
               `SPC_IDX_BASE_HI: st_nxt.rdata_r = {24'h0, st_r.base_hi_r};
               `SPC_IDX_BASE_LO: st_nxt.rdata_r = {24'h0, st_r.base_lo_r};
               `SPC_IDX_IRQ_SEL: st_nxt.rdata_r = {24'h0, st_r.irq_sel_r};
               `SPC_IDX_OPTIONS: st_nxt.rdata_r = {24'h0, st_r.options_r};
               `SPC_IDX_EVT_STATUS: st_nxt.rdata_r = 32'(st_r.evt_r);
               `SPC_IDX_EVT_MASK: st_nxt.rdata_r = 32'(st_r.mask_r);
               `SPC_IDX_CLK_STATUS: st_nxt.rdata_r = {29'h0, io_base_valid, clk_bus.sel};
               default: st_nxt.rdata_r = 32'h0;
            endcase
         end
      end
   end

   // Single state register, frozen while the clock enable is low.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.activate_r <= `SPC_RST_ACTIVATE;
         st_r.base_hi_r <= `SPC_RST_BASE_HI;
         st_r.base_lo_r <= `SPC_RST_BASE_LO;
         st_r.irq_sel_r <= `SPC_RST_IRQ_SEL;
         st_r.options_r <= `SPC_RST_OPTIONS;
      end else if (pclken) begin
         st_r <= st_nxt;
      end
   end

   // Baud generator steered by option bits 1:0.
   assign clk_bus.sel = st_r.options_r[1:0];
   assign clk_bus.run = st_r.activate_r[`SPC_BIT_ENABLE];
   spc_baud_gen u_baud (
      .ref_clk (ref_clk_24m),
      .ref_rstn (presetn),
      .clk_if (clk_bus.gen)
   );

   // Outputs.
   assign prdata = st_r.rdata_r;
   assign pready = st_r.rdy_r;
   assign pslverr = st_r.rdy_r && st_r.err_r;
   assign port_enable = st_r.activate_r[`SPC_BIT_ENABLE];
   assign io_base = {base_word[11:3], 3'h0};
   assign io_base_valid = io_base >= `SPC_BASE_MIN && io_base <= `SPC_BASE_MAX;
   assign irq_line = st_r.irq_sel_r[3:0];
   assign port_irq = st_r.pirq_r;
   assign fifo_err_flag = st_r.ferr_r;
   // The delay is one register stage; at 50 ns it exceeds the 5 ns minimum.
   assign rx_clk_out = st_r.options_r[`SPC_BIT_NO_RX_DELAY] ? st_r.rx_s2_r : st_r.rx_dly_r;
   assign baud_tick = clk_bus.tick;
   assign irq = |(st_r.evt_r & st_r.mask_r);

   // Activation write is visible on port_enable after the access.
   a_activate_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_en && idx[7:0] == `SPC_IDX_ACTIVATE) |=> port_enable == $past(pwdata[0]))
      else $error("activation bit not applied");
   // Base stays on an 8-byte boundary.
   a_base_aligned: assert property (@(posedge pclk) disable iff (!presetn)
      io_base[2:0] == 3'h0)
      else $error("base not aligned");
   // Selection reserved nibble and activation reserved bits stay zero.
   a_irq_sel_resv: assert property (@(posedge pclk) disable iff (!presetn)
      st_r.irq_sel_r[7:4] == 4'h0 && st_r.activate_r[7:1] == 7'h0)
      else $error("reserved bits set");
   // Delayed path lags the undelayed path by one cycle.
   a_rx_delay_path: assert property (@(posedge pclk) disable iff (!presetn)
      (pclken && !st_r.options_r[7]) [*2] |-> rx_clk_out == $past(st_r.rx_s2_r))
      else $error("receive clock delay wrong");
   // Pulse mode never holds the interrupt two cycles.
   a_pulse_mode: assert property (@(posedge pclk) disable iff (!presetn)
      (pclken && st_r.options_r[6] && port_irq) |=> !(pclken && port_irq))
      else $error("pulse interrupt too long");
   // Chosen FIFO flag follows the selected source.
   a_fifo_source: assert property (@(posedge pclk) disable iff (!presetn)
      (pclken && $stable(st_r.options_r[5])) |=>
         fifo_err_flag == ($past(st_r.options_r[5]) ? $past(st_r.fn_s2_r) : $past(st_r.fe_s2_r)))
      else $error("wrong FIFO flag source");
   // Options reserved bits and base high reserved nibble stay zero.
   a_options_resv: assert property (@(posedge pclk) disable iff (!presetn)
      st_r.options_r[4:2] == 3'h0 && st_r.base_hi_r[7:4] == 4'h0)
      else $error("reserved option bits set");
   // Every access phase is answered within two cycles.
   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && pclken) |-> ##[0:1] pready)
      else $error("access not answered");
endmodule : spc_config_regs

// ==== verif/spc_config_regs_tb.sv ====
// Self-checking testbench for the serial port configuration register bank.
`timescale 1ns/10ps
`include "spc_defs.svh"
module spc_config_regs_tb
   import spc_pkg::*;
();
   logic pclk; // APB clock, 50 ns period.
   logic presetn; // Asynchronous reset, active low.
   logic pclken; // Clock enable, held high throughout.
   logic psel; // APB select.
   logic penable; // APB enable.
   logic pwrite; // APB direction.
   logic [11:0] paddr; // APB byte address.
   logic [31:0] pwdata; // APB write data.
   logic [31:0] prdata; // APB read data.
   logic pready; // APB ready.
   logic pslverr; // APB error.
   logic ref_clk_24m; // Baud reference clock.
   logic uart_irq_req; // Port interrupt request.
   logic fifo_err_legacy; // Legacy FIFO error flag.
   logic fifo_err_revised; // Revised FIFO error flag.
   logic receive_sample_clock; // Raw receive clock.
   logic port_enable; // Port activated.
   logic [11:0] io_base; // Aligned base address.
   logic io_base_valid; // Base inside the legal window.
   logic [3:0] irq_line; // Chosen interrupt line.
   logic port_irq; // Shaped port interrupt.
   logic fifo_err_flag; // Chosen FIFO error flag.
   logic rx_clk_out; // Receive clock after the optional delay.
   logic baud_tick; // Baud reference tick.
   logic irq; // Block event interrupt.
   int errors; // Mismatches seen so far.
   int n_checks; // Comparisons made so far.
   int tick_cnt; // Baud ticks counted on the reference clock.
   int lat_a; // Receive clock latency with the delay.
   int lat_b; // Receive clock latency without the delay.
   int k; // Loop index.
   int c0; // Tick count snapshot.
   logic [31:0] q; // Last read data.
   logic e; // Last error response.
   int exp_ticks [4] = '{24, 26, 312, 192}; // Ticks in 312 reference periods per code.

   spc_config_regs u_dut (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ref_clk_24m(ref_clk_24m),
      .uart_irq_req(uart_irq_req), .fifo_err_legacy(fifo_err_legacy),
      .fifo_err_revised(fifo_err_revised), .receive_sample_clock(receive_sample_clock),
      .port_enable(port_enable), .io_base(io_base), .io_base_valid(io_base_valid),
      .irq_line(irq_line), .port_irq(port_irq), .fifo_err_flag(fifo_err_flag),
      .rx_clk_out(rx_clk_out), .baud_tick(baud_tick), .irq(irq));

   // The bus clock toggles every half period.
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // The reference clock runs unrelated in phase to the bus clock.
   initial begin
      ref_clk_24m = 1'b0;
      #7;
      forever #20.833 ref_clk_24m = ~ref_clk_24m;
   end

   // Ticks are counted in their own domain; the main flow only takes snapshots.
   initial tick_cnt = 0;
   always @(posedge ref_clk_24m) begin
      if (baud_tick === 1'b1) begin
         tick_cnt <= tick_cnt + 1;
      end
   end

   // Compares one value and counts it; an unknown never passes.
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Prints the verdict and stops the run.
   task end_of_test();
      if (errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test

   // One APB transfer, entered just after a rising edge; one idle edge follows.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // The request holds until pready is seen high; a hang counts as a mismatch.
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) begin
         errors++;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   // Register index to byte address, four bytes per register.
   function automatic logic [11:0] a4(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : a4

   // Write one register.
   task wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, a4(idx), {24'h000000, d});
   endtask : wr

   // Read one register and compare its word.
   task rdc(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, a4(idx), 32'h00000000);
      check(q, exp);
   endtask : rdc

   // Edges until the receive clock shows a raised input; the input drops afterwards.
   task rx_lat(output int n);
      n = 0;
      receive_sample_clock <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (rx_clk_out !== 1'b1 && n < 20);
      receive_sample_clock <= 1'b0;
      repeat (10) @(posedge pclk);
   endtask : rx_lat

   // Cycles in which the port interrupt is high over a short window.
   task count_irq(output int n);
      n = 0;
      repeat (12) begin
         @(posedge pclk);
         if (port_irq === 1'b1) begin
            n++;
         end
      end
   endtask : count_irq

   // A hang is cut short well after the tests should have finished.
   initial begin
      #2000000;
      errors++;
      end_of_test();
   end

   // Main sequence.
   initial begin
      errors = 0;
      n_checks = 0;
      presetn = 1'b0;
      pclken = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      uart_irq_req = 1'b0;
      fifo_err_legacy = 1'b1;
      fifo_err_revised = 1'b0;
      receive_sample_clock = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values of the activation, base, selection and option registers and of the io_base and irq_line outputs.
      rdc(`SPC_IDX_ACTIVATE, 32'h00000000);
      rdc(`SPC_IDX_BASE_HI, 32'h00000002);
      rdc(`SPC_IDX_BASE_LO, 32'h000000e8);
      rdc(`SPC_IDX_IRQ_SEL, 32'h00000003);
      rdc(`SPC_IDX_OPTIONS, 32'h00000000);
      check({20'h00000, io_base}, 32'h000002e8);
      check({28'h0000000, irq_line}, 32'h00000003);
      // While the port is inactive a raised request gives no port interrupt.
      uart_irq_req <= 1'b1;
      repeat (6) @(posedge pclk);
      check({31'h0, port_irq}, 32'h0);
      uart_irq_req <= 1'b0;
      // All ones written, options only to its reserved bits: reserved bits stay zero and the base stays aligned.
      wr(`SPC_IDX_ACTIVATE, 8'hff);
      wr(`SPC_IDX_BASE_HI, 8'hff);
      wr(`SPC_IDX_BASE_LO, 8'hff);
      wr(`SPC_IDX_IRQ_SEL, 8'hff);
      wr(`SPC_IDX_OPTIONS, 8'h1c);
      rdc(`SPC_IDX_ACTIVATE, 32'h00000001);
      rdc(`SPC_IDX_BASE_HI, 32'h0000000f);
      rdc(`SPC_IDX_BASE_LO, 32'h000000f8);
      rdc(`SPC_IDX_IRQ_SEL, 32'h0000000f);
      rdc(`SPC_IDX_OPTIONS, 32'h00000000);
      check({18'h0, port_enable, io_base_valid, io_base}, 32'h00003ff8);
      check({28'h0000000, irq_line}, 32'h0000000f);
      // Both sides of the lower edge of the legal base window.
      wr(`SPC_IDX_BASE_HI, 8'h00);
      check({19'h0, io_base_valid, io_base}, 32'h000000f8);
      wr(`SPC_IDX_BASE_HI, 8'h01);
      wr(`SPC_IDX_BASE_LO, 8'h00);
      check({19'h0, io_base_valid, io_base}, 32'h00001100);
      // An unmapped place answers with an error and reads zero.
      apb(1'b0, a4(8'h31), 32'h00000000);
      check({e, q[30:0]}, 32'h80000000);
      // Every clock source code, checked by readback and by tick rate.
      for (k = 0; k < 4; k++) begin
         wr(`SPC_IDX_OPTIONS, k[7:0]);
         rdc(`SPC_IDX_CLK_STATUS & 8'hff, 32'h00000004 | k);
         apb(1'b0, a4(`SPC_IDX_CLK_STATUS), 32'h00000000);
         check(q & 32'h3, k);
         repeat (20) @(posedge ref_clk_24m);
         c0 = tick_cnt;
         repeat (312) @(posedge ref_clk_24m);
         c0 = tick_cnt - c0 - exp_ticks[k];
         @(posedge pclk);
         check(32'(c0 >= -1 && c0 <= 1), 32'h1);
      end
      // The receive clock is one stage later with the delay than without.
      wr(`SPC_IDX_OPTIONS, 8'h00);
      rx_lat(lat_a);
      wr(`SPC_IDX_OPTIONS, 8'h80);
      rx_lat(lat_b);
      check(lat_a - lat_b, 32'h1);
      // FIFO error source follows option bit 5.
      check({31'h0, fifo_err_flag}, 32'h1);
      wr(`SPC_IDX_OPTIONS, 8'h20);
      repeat (4) @(posedge pclk);
      check({31'h0, fifo_err_flag}, 32'h0);
      // Level mode holds while requested; pulse mode gives one cycle.
      wr(`SPC_IDX_OPTIONS, 8'h00);
      uart_irq_req <= 1'b1;
      count_irq(k);
      check(k, 32'd9);
      uart_irq_req <= 1'b0;
      repeat (6) @(posedge pclk);
      wr(`SPC_IDX_OPTIONS, 8'h40);
      uart_irq_req <= 1'b1;
      count_irq(k);
      check(k, 32'd1);
      uart_irq_req <= 1'b0;
      // Events: masked, unmasked, then cleared by writing one.
      wr(`SPC_IDX_EVT_MASK, 8'h00);
      wr(`SPC_IDX_EVT_STATUS, 8'hff);
      check({31'h0, irq}, 32'h0);
      uart_irq_req <= 1'b1;
      repeat (6) @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      wr(`SPC_IDX_EVT_MASK, 8'h01);
      rdc(`SPC_IDX_EVT_MASK, 32'h00000001);
      check({31'h0, irq}, 32'h1);
      uart_irq_req <= 1'b0;
      wr(`SPC_IDX_EVT_STATUS, 8'h01);
      check({31'h0, irq}, 32'h0);
      end_of_test();
   end
endmodule : spc_config_regs_tb
